// [rtl/epv_pkg.sv]
// Purpose: Shared constants and types for the exception prioritisation unit.
// Assumes: 32-bit core, registers reached over Avalon-MM with waitrequest.
// Notes:   Rules follow.
// Contract
// - Reset, master clear: boot select, error level.
// - Soft reset: boot select, soft reset, error level.
// - Single step: debug vector, step bit only.
// - Debug interrupt from pin or break request.
// - NMI: boot select, NMI flag, error level.
// - Unmasked interrupt: priority level, cause zero.
// - Deferred watch: pending bit, exc level, 0x17.
// - Instruction break: debug vector, instr break bit.
// - Fetch watch: general vector, exc level, 0x17.
// - Fetch address error: exc level, cause 0x04.
// - Fetch bus error: exc level, cause 0x06.
// - Coprocessor unusable beats reserved instruction.
// - Execute exceptions: causes 0x08-0x0C, exc level.
// - True trap: general vector, exc level, 0x0D.
// - Data break: debug vector, load/store bit.
// - Data watch: exc level, cause 0x17.
// - Fixed priority picks one winner.
// - Config four bit31 one, 30-24 zero.
// - Scratch present field reads all zero.
// - Config four low half reads zero.
package epv_pkg;
  // Vectors and offsets.
  localparam logic [31:0] BOOT_VECTOR   = 32'hBFC0_0000;
  localparam logic [31:0] DEBUG_VECTOR  = 32'hBFC0_0480;
  localparam logic [31:0] GEN_OFFSET    = 32'h0000_0180;
  localparam logic [31:0] INT_OFFSET    = 32'h0000_0200;
  localparam logic [31:0] XBASE_RESET   = 32'h8000_0000;
  // Cause codes.
  localparam logic [4:0] CAUSE_INT     = 5'h00;
  localparam logic [4:0] CAUSE_FADR    = 5'h04;
  localparam logic [4:0] CAUSE_FBE     = 5'h06;
  localparam logic [4:0] CAUSE_EXEC_LO = 5'h08;
  localparam logic [4:0] CAUSE_RI      = 5'h0A;
  localparam logic [4:0] CAUSE_CPU     = 5'h0B;
  localparam logic [4:0] CAUSE_EXEC_HI = 5'h0C;
  localparam logic [4:0] CAUSE_TRAP    = 5'h0D;
  localparam logic [4:0] CAUSE_WATCH   = 5'h17;
  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_CAUSE     = 8'h04;
  localparam logic [7:0] OFS_EPC       = 8'h08;
  localparam logic [7:0] OFS_XBASE     = 8'h0C;
  localparam logic [7:0] OFS_DBG_STAT  = 8'h10;
  localparam logic [7:0] OFS_DBG_CTRL  = 8'h14;
  localparam logic [7:0] OFS_CFG4      = 8'h18;
  localparam logic [7:0] OFS_INT_MASK  = 8'h1C;
  // Status register field positions.
  localparam int ST_EXC  = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_BOOT = 2;
  localparam int ST_SRST = 3;
  localparam int ST_NMI  = 4;
  localparam int ST_WP   = 5;
  localparam int ST_PRI  = 8;
  // Debug status field positions.
  localparam int DS_SS   = 0;
  localparam int DS_INT  = 1;
  localparam int DS_IB   = 2;
  localparam int DS_DBL  = 3;
  localparam int DS_DBS  = 4;
  // Debug control break request bit.
  localparam int DC_BRK  = 0;
  // Config four read value: bit31 set, everything else zero.
  localparam logic [31:0] CFG4_VALUE    = 32'h8000_0000;
  localparam logic [7:0]  KSCR_PRESENT  = 8'h00;
  localparam int          CFG4_M_BIT    = 31;
  localparam int          CFG4_KSCR_LSB = 16;

  // Exception requests from the pipeline and debug unit.
  typedef struct packed {
    logic       soft_reset;
    logic       debug_step;
    logic       nmi;
    logic       deferred_watch;
    logic       instr_break;
    logic       fetch_watch;
    logic       fetch_addr_err;
    logic       fetch_bus_err;
    logic       cop_unusable;
    logic       reserved_instr;
    logic       exec_exc;
    logic [4:0] exec_code;
    logic       trap_true;
    logic       data_break_load;
    logic       data_break_store;
    logic       data_watch;
  } epv_req_t;

  // Winner of one cycle's arbitration.
  typedef enum logic [4:0] {
    EPV_NONE, EPV_RESET, EPV_SOFT, EPV_STEP, EPV_DIRQ, EPV_NMI, EPV_INT,
    EPV_DWATCH, EPV_IBRK, EPV_FWATCH, EPV_FADR, EPV_FBE, EPV_CPU, EPV_RI,
    EPV_EXEC, EPV_TRAP, EPV_DDB, EPV_DWATCHD
  } epv_kind_t;
endpackage

// [rtl/epv_unit.sv]
// Purpose: Ranks pending exceptions, picks the vector and updates status.
// Assumes: Request inputs are synchronous levels sampled every cycle.
// Notes:   One exception is taken per cycle; the pipeline drops its request
//          once it sees the redirect pulse.
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module epv_unit
  import epv_pkg::*;
(
  input  wire logic        clk_in,                // Core clock, 125 MHz.
  input  wire logic        rst_n_in,              // Power-on reset, async.
  input  wire logic        master_clear_input_in, // Master clear level.
  input  wire logic        ext_debug_interrupt_in,// Debug interrupt pin.
  input  wire epv_req_t    req_in,                // Exception requests.
  input  wire logic [7:0]  irq_in,                // Interrupt lines.
  input  wire logic [31:0] fault_pc_in,           // PC of faulting instr.
  input  wire logic [7:0]  avs_address_in,        // Byte address.
  input  wire logic        avs_read_in,           // Read strobe.
  input  wire logic        avs_write_in,          // Write strobe.
  input  wire logic [31:0] avs_writedata_in,      // Write data.
  input  wire logic [3:0]  avs_byteenable_in,     // Byte lanes.
  output logic [31:0]      avs_readdata_out,      // Read data.
  output logic             avs_waitrequest_out,   // Stall.
  output logic             redirect_out,          // Take pulse.
  output logic [31:0]      redirect_pc_out,       // New fetch address.
  output logic [4:0]       cause_out,             // Cause of last ordinary take.
  output logic             debug_mode_out         // Debug vector taken.
);

  // Architectural state.
  logic [31:0] status;
  logic [31:0] debug_status;
  logic [31:0] debug_control_reg;
  logic [31:0] exception_base;
  logic [31:0] epc;
  logic [4:0]  cause_code;
  logic [7:0]  int_mask;
  logic        reset_pending;

  // Arbitration results.
  epv_kind_t   next_kind;
  logic [31:0] next_pc;
  logic [4:0]  next_cause;
  logic [2:0]  next_ipl;
  logic [7:0]  irq_live;
  logic        dirq_req;

  // Bus decode.
  logic        bus_req;
  logic        bus_write;
  logic [31:0] next_readdata;

  // Merge write data into a register under byte enables.
  function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Base plus offset for the base-relative vectors.
  function automatic logic [31:0] base_vec(input logic [31:0] base,
                                           input logic [31:0] ofs);
    return base + ofs;
  endfunction

  // A bus request is taken on its second cycle, when waitrequest is low.
  assign bus_req   = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  assign bus_write = avs_write_in & ~avs_waitrequest_out;

  // Interrupts are gated by the mask and blocked while either level is set.
  assign irq_live = irq_in & int_mask
                    & {8{~status[ST_EXC] & ~status[ST_ERR]}};
  // Debug interrupt comes from the pin or the software break request.
  assign dirq_req = ext_debug_interrupt_in
                    | debug_control_reg[DC_BRK];

  // Fixed priority arbitration; the first true line wins.
  always_comb begin
    next_kind  = EPV_NONE;
    next_pc    = BOOT_VECTOR;
    next_cause = cause_code;
    next_ipl   = status[ST_PRI +: 3];
    for (int i = 0; i < 8; i++) begin
      if (irq_live[i]) begin
        next_ipl = 3'(i);
      end
    end
    if (reset_pending || master_clear_input_in) begin
      next_kind = EPV_RESET;
    end else if (req_in.soft_reset) begin
      next_kind = EPV_SOFT;
    end else if (req_in.debug_step) begin
      next_kind = EPV_STEP;
      next_pc   = DEBUG_VECTOR;
    end else if (dirq_req) begin
      next_kind = EPV_DIRQ;
      next_pc   = DEBUG_VECTOR;
    end else if (req_in.nmi) begin
      next_kind = EPV_NMI;
    end else if (|irq_live) begin
      next_kind  = EPV_INT;
      next_pc    = base_vec(exception_base, INT_OFFSET);
      next_cause = CAUSE_INT;
    end else if (req_in.deferred_watch) begin
      next_kind  = EPV_DWATCH;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_WATCH;
    end else if (req_in.instr_break) begin
      next_kind = EPV_IBRK;
      next_pc   = DEBUG_VECTOR;
    end else if (req_in.fetch_watch) begin
      next_kind  = EPV_FWATCH;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_WATCH;
    end else if (req_in.fetch_addr_err) begin
      next_kind  = EPV_FADR;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_FADR;
    end else if (req_in.fetch_bus_err) begin
      next_kind  = EPV_FBE;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_FBE;
    end else if (req_in.cop_unusable) begin
      next_kind  = EPV_CPU;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_CPU;
    end else if (req_in.reserved_instr) begin
      next_kind  = EPV_RI;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_RI;
    end else if (req_in.exec_exc
                 && req_in.exec_code >= CAUSE_EXEC_LO
                 && req_in.exec_code <= CAUSE_EXEC_HI) begin
      // Codes outside the execute range are ignored, not remapped.
      next_kind  = EPV_EXEC;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = req_in.exec_code;
    end else if (req_in.trap_true) begin
      next_kind  = EPV_TRAP;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_TRAP;
    end else if (req_in.data_break_load || req_in.data_break_store) begin
      next_kind = EPV_DDB;
      next_pc   = DEBUG_VECTOR;
    end else if (req_in.data_watch) begin
      next_kind  = EPV_DWATCHD;
      next_pc    = base_vec(exception_base, GEN_OFFSET);
      next_cause = CAUSE_WATCH;
    end
  end

  // Reset is taken as an exception on the first edge after release.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_pending <= 1'b1;
    end else begin
      reset_pending <= 1'b0;
    end
  end

  // Redirect outputs: one-cycle pulse with the vector and debug flag.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      redirect_out    <= 1'b0;
      redirect_pc_out <= BOOT_VECTOR;
      debug_mode_out  <= 1'b0;
    end else begin
      redirect_out <= (next_kind != EPV_NONE);
      if (next_kind != EPV_NONE) begin
        redirect_pc_out <= next_pc;
        debug_mode_out  <= (next_pc == DEBUG_VECTOR);
      end
    end
  end

  // Cause and fault PC are captured at the very edge of the take.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_code <= 5'h00;
      epc        <= 32'h0000_0000;
    end else begin
      if (bus_write && avs_address_in == OFS_EPC) begin
        epc <= merge_be(epc, avs_writedata_in, avs_byteenable_in);
      end
      // Ordinary exceptions override a same-cycle software write.
      if (next_kind >= EPV_INT && next_kind != EPV_IBRK
          && next_kind != EPV_DDB) begin
        cause_code <= next_cause;
        epc        <= fault_pc_in;
      end
    end
  end

  // Status: software writes, hardware sets win in the same cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= 32'h0000_0000;
      status[ST_BOOT] <= 1'b1;
      status[ST_ERR]  <= 1'b1;
    end else begin
      if (bus_write && avs_address_in == OFS_STATUS) begin
        status <= merge_be(status, avs_writedata_in, avs_byteenable_in)
                  & 32'h0000_073F;
      end
      case (next_kind)
        EPV_RESET: begin
          status[ST_BOOT] <= 1'b1;
          status[ST_ERR]  <= 1'b1;
          status[ST_SRST] <= 1'b0;
          status[ST_NMI]  <= 1'b0;
        end
        EPV_SOFT: begin
          status[ST_BOOT] <= 1'b1;
          status[ST_SRST] <= 1'b1;
          status[ST_ERR]  <= 1'b1;
        end
        EPV_NMI: begin
          status[ST_BOOT] <= 1'b1;
          status[ST_NMI]  <= 1'b1;
          status[ST_ERR]  <= 1'b1;
        end
        EPV_INT: begin
          status[ST_PRI +: 3] <= next_ipl;
          status[ST_EXC]      <= 1'b1;
        end
        EPV_DWATCH: begin
          status[ST_WP]  <= 1'b1;
          status[ST_EXC] <= 1'b1;
        end
        EPV_FWATCH, EPV_FADR, EPV_FBE, EPV_CPU, EPV_RI, EPV_EXEC,
        EPV_TRAP, EPV_DWATCHD: begin
          status[ST_EXC] <= 1'b1;
        end
        default: begin
          // Debug entries leave the ordinary status untouched.
        end
      endcase
    end
  end

  // Debug status bits are sticky until software writes them clear; a data break rewrites both the load and store bits.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      debug_status <= 32'h0000_0000;
    end else begin
      if (bus_write && avs_address_in == OFS_DBG_STAT) begin
        debug_status <= merge_be(debug_status, avs_writedata_in,
                                 avs_byteenable_in) & 32'h0000_001F;
      end
      case (next_kind)
        EPV_STEP: debug_status[DS_SS]  <= 1'b1;
        EPV_DIRQ: debug_status[DS_INT] <= 1'b1;
        EPV_IBRK: debug_status[DS_IB]  <= 1'b1;
        EPV_DDB: begin
          debug_status[DS_DBL] <= req_in.data_break_load;
          debug_status[DS_DBS] <= ~req_in.data_break_load;
        end
        default: begin
        end
      endcase
    end
  end

  // Break request is consumed by the debug interrupt; a write wins.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      debug_control_reg <= 32'h0000_0000;
    end else begin
      if (next_kind == EPV_DIRQ) begin
        debug_control_reg[DC_BRK] <= 1'b0;
      end
      if (bus_write && avs_address_in == OFS_DBG_CTRL) begin
        debug_control_reg <= merge_be(debug_control_reg, avs_writedata_in,
                                      avs_byteenable_in) & 32'h0000_0001;
      end
    end
  end

  // Base and mask registers steer the vector and the interrupt gate.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exception_base <= XBASE_RESET;
      int_mask       <= 8'h00;
    end else if (bus_write) begin
      if (avs_address_in == OFS_XBASE) begin
        // Low bits stay zero so the vector is always aligned.
        exception_base <= merge_be(exception_base, avs_writedata_in,
                                   avs_byteenable_in) & 32'hFFFF_F000;
      end
      if (avs_address_in == OFS_INT_MASK && avs_byteenable_in[0]) begin
        int_mask <= avs_writedata_in[7:0];
      end
    end
  end

  // Read mux; unmapped addresses return zero.
  always_comb begin
    case (avs_address_in)
      OFS_STATUS:   next_readdata = status;
      OFS_CAUSE:    next_readdata = {27'h0, cause_code};
      OFS_EPC:      next_readdata = epc;
      OFS_XBASE:    next_readdata = exception_base;
      OFS_DBG_STAT: next_readdata = debug_status;
      OFS_DBG_CTRL: next_readdata = debug_control_reg;
      // Writes here are dropped; the value is fixed.
      OFS_CFG4:     next_readdata = CFG4_VALUE;
      OFS_INT_MASK: next_readdata = {24'h000000, int_mask};
      default:      next_readdata = 32'h0000_0000;
    endcase
  end

  // One wait state per access so read data comes from a flop.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      if (bus_req) begin
        avs_waitrequest_out <= 1'b1;
      end else if (avs_read_in || avs_write_in) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= next_readdata;
      end
    end
  end

  // Cause output mirrors the cause register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_out <= 5'h00;
    end else begin
      cause_out <= cause_code;
    end
  end

endmodule
`default_nettype wire

// [tb/epv_pipe_model.sv]
// Purpose: Pipeline and debug side that raises exception requests.
// Assumes: Requests are levels, dropped once the take pulse is seen.
// Notes:   Gives up after ten cycles so a refused request cannot hang.
`timescale 1ns/1ps
`default_nettype none
module epv_pipe_model
  import epv_pkg::*;
(
  input  wire logic        clk_in,         // Core clock.
  input  wire logic        redirect_in,    // Take pulse.
  input  wire logic [31:0] redirect_pc_in, // Vector.
  output var epv_req_t     req_out,        // Requests.
  output logic [7:0]       irq_out,        // Interrupt lines.
  output logic             dbg_int_out     // Debug pin.
);
  // Nothing is pending at time zero.
  initial begin
    req_out = '0;
    irq_out = 8'h00;
    dbg_int_out = 1'b0;
  end
  // Raise after an edge, hold until the pulse is sampled, then release.
  task automatic fire(input epv_req_t r, input logic [7:0] i,
                      input logic d, output logic seen,
                      output logic [31:0] pc);
    seen = 1'b0;
    pc = 32'h0;
    @(posedge clk_in);
    req_out <= r;
    irq_out <= i;
    dbg_int_out <= d;
    for (int n = 0; n < 10 && !seen; n++) begin
      @(posedge clk_in);
      seen = (redirect_in === 1'b1);
      pc = seen ? redirect_pc_in : 32'h0;
    end
    req_out <= '0;
    irq_out <= 8'h00;
    dbg_int_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/epv_unit_sva.sv]
// Purpose: Concurrent checks on the exception unit's ports.
// Assumes: Exception base is left at its reset value by the bench.
// Notes:   Held requests are retaken each cycle, so checks look one take on.
`timescale 1ns/1ps
`default_nettype none
module epv_unit_sva
  import epv_pkg::*;
(
  input wire logic        clk_in,                 // Core clock.
  input wire logic        rst_n_in,               // Async reset, low.
  input wire logic        master_clear_input_in,  // Master clear.
  input wire logic        ext_debug_interrupt_in, // Debug pin.
  input wire epv_req_t    req_in,                 // Requests.
  input wire logic [7:0]  irq_in,                 // Interrupt lines.
  input wire logic [7:0]  avs_address_in,         // Bus address.
  input wire logic        avs_read_in,            // Bus read.
  input wire logic [31:0] avs_readdata_out,       // Bus read data.
  input wire logic        avs_waitrequest_out,    // Bus stall.
  input wire logic        redirect_out,           // Take pulse.
  input wire logic [31:0] redirect_pc_out,        // Vector.
  input wire logic [4:0]  cause_out,              // Cause code.
  input wire logic        debug_mode_out          // Debug vector taken.
);
  localparam epv_req_t ONLY_FBE = '{fetch_bus_err: 1'b1, default: '0};
  localparam epv_req_t ONLY_CPU = '{cop_unusable: 1'b1,
                                    reserved_instr: 1'b1, default: '0};
  localparam epv_req_t ONLY_TRAP = '{trap_true: 1'b1, default: '0};
  logic quiet;
  logic top3;
  // No reset, debug pin or interrupt line competes with a general request.
  assign quiet = !master_clear_input_in && !ext_debug_interrupt_in &&
                 irq_in == 8'h00;
  assign top3  = !master_clear_input_in && !req_in.soft_reset;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_MRST: assert property (
    master_clear_input_in |=> redirect_out && redirect_pc_out == 32'hBFC0_0000)
    else $error("Master clear did not vector to the boot address.");
  AST_SOFT: assert property (
    req_in.soft_reset && !master_clear_input_in |=> redirect_out &&
    redirect_pc_out == 32'hBFC0_0000 && !debug_mode_out)
    else $error("Soft reset did not vector to the boot address.");
  AST_STEP: assert property (
    req_in.debug_step && top3 |=> redirect_out && debug_mode_out &&
    redirect_pc_out == 32'hBFC0_0480)
    else $error("Single step did not reach the debug vector.");
  AST_DIRQ: assert property (
    ext_debug_interrupt_in && top3 && !req_in.debug_step |=>
    debug_mode_out && redirect_pc_out == 32'hBFC0_0480)
    else $error("Debug pin did not reach the debug vector.");
  AST_NMI: assert property (
    req_in.nmi && top3 && !req_in.debug_step && !ext_debug_interrupt_in |=>
    redirect_out && !debug_mode_out && redirect_pc_out == 32'hBFC0_0000)
    else $error("NMI did not vector to the boot address.");
  AST_FBE: assert property (
    quiet && req_in == ONLY_FBE |=> redirect_out ##1 cause_out == 5'h06)
    else $error("Fetch bus error cause is wrong.");
  AST_CPU: assert property (
    quiet && req_in == ONLY_CPU |=> ##1 cause_out == 5'h0B)
    else $error("Coprocessor unusable did not win over reserved.");
  AST_TRAP: assert property (
    quiet && req_in == ONLY_TRAP |=> redirect_out && !debug_mode_out ##1
    cause_out == 5'h0D)
    else $error("Trap cause is wrong.");
  AST_CFG4: assert property (
    avs_read_in && avs_address_in == OFS_CFG4 && !avs_waitrequest_out |->
    avs_readdata_out == 32'h8000_0000)
    else $error("Config four read value is wrong.");
endmodule
bind epv_unit epv_unit_sva u_epv_unit_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in),
  .master_clear_input_in(master_clear_input_in),
  .ext_debug_interrupt_in(ext_debug_interrupt_in), .req_in(req_in),
  .irq_in(irq_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .redirect_out(redirect_out),
  .redirect_pc_out(redirect_pc_out), .cause_out(cause_out),
  .debug_mode_out(debug_mode_out));
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the exception unit.
// Assumes: Exception base stays at reset, so vectors are fixed values.
// Notes:   Each row packs vector kind, status, debug status and cause.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import epv_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        m_clr = 1'b0;
  logic [31:0] fault_pc = 32'h0;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic [31:0] redirect_pc_out;
  logic        avs_waitrequest_out;
  logic        redirect_out;
  logic        debug_mode_out;
  logic        dbg_int;
  logic [4:0]  cause_out;
  logic [7:0]  irq;
  epv_req_t    req;
  int          n_fail = 0;
  int          checks = 0;
  // Kind 0 general, 1 debug, 2 boot; then status, debug status, cause.
  localparam logic [31:0] EXP [21] = '{
    32'h0001_0017, 32'h0001_0004, 32'h0001_0006, 32'h0001_000B, // 12
    32'h0001_000A, 32'h0001_0008, 32'h0001_0009, 32'h0001_000A,
    32'h0001_000B, 32'h0001_000C, 32'h0001_000D, 32'h0001_0017, // 16
    32'h0021_0017, 32'h1000_0100, 32'h1000_0400, 32'h1000_0800,
    32'h1000_1000, 32'h200E_0000, 32'h2016_0000, 32'h2016_0000,
    32'h1000_0100};
  // The clock runs at 125 MHz.
  always #4 clk_in = ~clk_in;
  epv_unit u_epv_unit (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .master_clear_input_in(m_clr),
    .ext_debug_interrupt_in(dbg_int), .req_in(req), .irq_in(irq),
    .fault_pc_in(fault_pc), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .redirect_out(redirect_out),
    .redirect_pc_out(redirect_pc_out), .cause_out(cause_out),
    .debug_mode_out(debug_mode_out));
  epv_pipe_model u_epv_pipe_model (
    .clk_in(clk_in), .redirect_in(redirect_out),
    .redirect_pc_in(redirect_pc_out), .req_out(req), .irq_out(irq),
    .dbg_int_out(dbg_int));
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low at an edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // Builds the request of row k; rows 18 to 20 add an NMI, alone in row 18 and competing in rows 19 and 20.
  function automatic epv_req_t mk(input int k);
    epv_req_t r;
    r = '0;
    case (k)
      0: r.fetch_watch = 1'b1;
      1: r.fetch_addr_err = 1'b1;
      2, 19: r.fetch_bus_err = 1'b1;
      3: r.cop_unusable = 1'b1;
      10: r.trap_true = 1'b1;
      11: r.data_watch = 1'b1;
      12: r.deferred_watch = 1'b1;
      13, 20: r.debug_step = 1'b1;
      14: r.instr_break = 1'b1;
      15: r.data_break_load = 1'b1;
      16: r.data_break_store = 1'b1;
      17: r.soft_reset = 1'b1;
      default: r.exec_exc = (k >= 5 && k <= 9);
    endcase
    r.reserved_instr = (k == 3 || k == 4);
    r.nmi = (k >= 18);
    r.exec_code = (k >= 5 && k <= 9) ? 5'(k + 3) : 5'h00;
    return r;
  endfunction
  // Main sequence: reset, config four, every request kind, debug, irq.
  initial begin
    logic [31:0] pc;
    logic [31:0] e;
    logic        seen;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    u_epv_pipe_model.fire('0, 8'h00, 1'b0, seen, pc);
    chk("reset vector", pc, 32'hBFC0_0000);
    rdc("reset status", OFS_STATUS, 32'h0000_0006);
    rdc("config four", OFS_CFG4, 32'h8000_0000);
    wr(OFS_CFG4, 32'h7FFF_0000);
    rdc("config four kept", OFS_CFG4, 32'h8000_0000);
    rdc("unmapped", 8'hF0, 32'h0000_0000);
    m_clr <= 1'b1;
    u_epv_pipe_model.fire('0, 8'h00, 1'b0, seen, pc);
    m_clr <= 1'b0;
    chk("clear vector", pc, 32'hBFC0_0000);
    for (int k = 0; k < 21; k++) begin
      e = EXP[k];
      wr(OFS_STATUS, 32'h0);
      wr(OFS_DBG_STAT, 32'h0);
      fault_pc <= 32'h0000_4000 + 32'(k * 4);
      u_epv_pipe_model.fire(mk(k), 8'h00, 1'b0, seen, pc);
      chk("vector", pc, (e[31:28] == 4'h0) ? 32'h8000_0180 :
          (e[31:28] == 4'h1) ? 32'hBFC0_0480 : 32'hBFC0_0000);
      rdc("status", OFS_STATUS, {20'h0, e[27:16]});
      rdc("debug status", OFS_DBG_STAT, {24'h0, e[15:8]});
      if (e[31:28] == 4'h0) begin
        rdc("fault pc", OFS_EPC, 32'h0000_4000 + 32'(k * 4));
        chk("cause", {27'h0, cause_out}, {24'h0, e[7:0]});
      end
    end
    wr(OFS_DBG_STAT, 32'h0);
    u_epv_pipe_model.fire('0, 8'h00, 1'b1, seen, pc);
    chk("pin debug vector", pc, 32'hBFC0_0480);
    rdc("pin debug status", OFS_DBG_STAT, 32'h0000_0002);
    wr(OFS_DBG_STAT, 32'h0);
    wr(OFS_DBG_CTRL, 32'h0000_0001);
    u_epv_pipe_model.fire('0, 8'h00, 1'b0, seen, pc);
    chk("break debug vector", pc, 32'hBFC0_0480);
    rdc("break debug status", OFS_DBG_STAT, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_INT_MASK, 32'h0);
    u_epv_pipe_model.fire('0, 8'h20, 1'b0, seen, pc);
    chk("masked irq", {31'h0, seen}, 32'h0);
    wr(OFS_INT_MASK, 32'h0000_00FF);
    u_epv_pipe_model.fire('0, 8'h20, 1'b0, seen, pc);
    chk("irq vector", pc, 32'h8000_0200);
    rdc("irq status", OFS_STATUS, 32'h0000_0501);
    chk("irq cause", {27'h0, cause_out}, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
